// [pkg/ris_params.svh]
// timing, offsets, field positions and reset values of the input switch control
`ifndef RIS_PARAMS_SVH
`define RIS_PARAMS_SVH
`define RIS_CLK_HZ          25000000
`define RIS_PILOT_LOSS_MS   10
`define RIS_PILOT_LOSS_CYC  (`RIS_PILOT_LOSS_MS * (`RIS_CLK_HZ / 1000))
`define RIS_WD_PERIOD_MS    2000
`define RIS_WD_CYC          (`RIS_WD_PERIOD_MS * (`RIS_CLK_HZ / 1000))
`define RIS_DEB_MS          10
`define RIS_DEB_CYC         (`RIS_DEB_MS * (`RIS_CLK_HZ / 1000))
`define RIS_SELFTEST_MS     1000
`define RIS_SELFTEST_CYC    (`RIS_SELFTEST_MS * (`RIS_CLK_HZ / 1000))
`define RIS_MARK_HOLD_MS    1
`define RIS_MARK_HOLD_CYC   (`RIS_MARK_HOLD_MS * (`RIS_CLK_HZ / 1000))
`define RIS_BLINK_MS        125
`define RIS_BLINK_CYC       (`RIS_BLINK_MS * (`RIS_CLK_HZ / 1000))
`define RIS_PILOT_CH_1FS    6'h37
`define RIS_PILOT_CH_2FS    6'h1B
`define RIS_PILOT_THRESH    24'h010000
`define RIS_REG_CTRL        4'h0
`define RIS_REG_STATUS      4'h4
`define RIS_CTRL_MODE_LSB   0
`define RIS_MODE_RESET      4'h0
`define RIS_N_CONTACTS      6
`endif

// [pkg/ris_pkg.sv]
// types of the input switch control
package ris_pkg;
  typedef enum logic [3:0] {
    RIS_MANUAL, RIS_LOCK1, RIS_LOCK2, RIS_LOCK_RED,
    RIS_MARK1, RIS_MARK2, RIS_MARK_RED, RIS_WD1, RIS_WD2,
    RIS_PILOT1, RIS_PILOT2, RIS_PILOT_RED
  } ris_mode_e;
endpackage : ris_pkg

// [pkg/ris_contact_if.sv]
// debounced contact and button signals between conditioner and controller
`timescale 1ns/1ps
interface ris_contact_if #(parameter int N = 6);
  logic [N-1:0] raw;
  logic [N-1:0] level;
  logic [N-1:0] press;
  logic [N-1:0] change;
  modport cond (input raw, output level, press, change);
  modport ctl  (output raw, input level, press, change);
endinterface : ris_contact_if

// [hw/ris_debounce.sv]
// two-stage sync and debounce for each contact and button
`timescale 1ns/1ps
`include "ris_params.svh"
module ris_debounce #(
  parameter int N       = `RIS_N_CONTACTS,
  parameter int DEB_CYC = `RIS_DEB_CYC
) (
  // clock and reset
  input  wire logic   core_clk_in,
  input  wire logic   reset_in,
  // contacts
  ris_contact_if.cond c_if
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      logic        s1_ff, s2_ff, lvl_ff, prs_ff, chg_ff;
      logic [31:0] cnt_ff;
      // second stage only sees the first; a change must stand DEB_CYC cycles
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          s1_ff  <= 1'b0;
          s2_ff  <= 1'b0;
          lvl_ff <= 1'b0;
          prs_ff <= 1'b0;
          chg_ff <= 1'b0;
          cnt_ff <= 32'h0;
        end else begin
          s1_ff  <= c_if.raw[i];
          s2_ff  <= s1_ff;
          prs_ff <= 1'b0;
          chg_ff <= 1'b0;
          if (s2_ff == lvl_ff) begin
            cnt_ff <= 32'h0;
          end else if (cnt_ff >= 32'(DEB_CYC - 1)) begin
            lvl_ff <= s2_ff;
            prs_ff <= s2_ff;
            chg_ff <= 1'b1;
            cnt_ff <= 32'h0;
          end else begin
            cnt_ff <= cnt_ff + 32'h1;
          end
        end
      end
      assign c_if.level[i]  = lvl_ff;
      assign c_if.press[i]  = prs_ff;
      assign c_if.change[i] = chg_ff;
    end
  endgenerate
endmodule : ris_debounce

// [hw/ris_switch_ctrl.sv]
// selection, indicator and register logic of the two-input redundancy switch
//
// Functional notes
// R1 - marker led on only if marker present and input feeds output; heartbeat in watchdog
// R2 - port led off unselected, blinks selected without signal, on selected with signal
// R3 - priority button or remote input 4 advances the priority mode
// R4 - manual, automatic without revert and automatic with revert behaviours
// R5 - manual mode: select press toggles the input, no automatic switch-over
// R6 - lock priority: fall back on lock loss, return on lock, ignore select
// R7 - lock redundancy: switch on loss, no revert, select only if both locked
// R8 - marker priority: needs lock and marker, returns on marker, ignores select
// R9 - marker redundancy: switch on marker loss, no revert, select if both marked
// R10 - watchdog mode: needs lock and toggling contact, switch away and return
// R11 - pilot priority: needs lock and tone, returns on tone, ignores select
// R12 - pilot redundancy: switch after tone gone over 10 ms, no revert
// R13 - pilot tone is level above threshold in channel 56, or 28 at double rate
// R14 - tone loss after more than 10 ms absence, restored at once
// R15 - remote 1 and 2 force an input or trigger watchdog; 3 and 4 mimic buttons
// R16 - watchdog holds only while remote 1 or 2 keeps changing state
// R17 - outside equipment toggles the watchdog contact at least every two seconds
// R18 - watchdog active blinks all three indicator sections
// R19 - power-up self test: port led blinks for closed contact, off for open
// R20 - loop marker searched in channels 8,16,...,64
// R21 - 88.2 and 96 kHz count as double rate, channel positions scaled
// R22 - priority action steps cyclically through the modes, wrapping to manual
// R23 - contacts and buttons are synchronised and debounced before use
`timescale 1ns/1ps
`include "ris_params.svh"
module ris_switch_ctrl
  import ris_pkg::*;
#(
  parameter int PILOT_LOSS_CYC = `RIS_PILOT_LOSS_CYC,
  parameter int WD_CYC         = `RIS_WD_CYC,
  parameter int DEB_CYC        = `RIS_DEB_CYC,
  parameter int SELFTEST_CYC   = `RIS_SELFTEST_CYC,
  parameter int MARK_HOLD_CYC  = `RIS_MARK_HOLD_CYC,
  parameter int BLINK_CYC      = `RIS_BLINK_CYC
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // contact pins and front buttons
  input  wire logic [3:0]  remote_control_input_in,
  input  wire logic        btn_select_in,
  input  wire logic        btn_priority_in,
  // per input status, same clock domain
  input  wire logic [1:0]  lock_in,
  input  wire logic [1:0]  double_rate_in,
  input  wire logic [1:0]  smp_valid_in,
  input  wire logic [11:0] smp_chan_in,
  input  wire logic [47:0] smp_level_in,
  input  wire logic [1:0]  loop_marker_signal_in,
  // selection and indicators
  output logic             sel_input_out,
  output logic [1:0]       port_led_out,
  output logic [1:0]       marker_led_out,
  output logic [3:0]       mode_led_out,
  output logic             mode_led_en_out
);
  ris_contact_if #(.N(`RIS_N_CONTACTS)) c_if ();

  // contacts 0..3 remote, 4 select button, 5 priority button
  assign c_if.raw = {btn_priority_in, btn_select_in, remote_control_input_in};
  ris_debounce #(.N(`RIS_N_CONTACTS), .DEB_CYC(DEB_CYC)) u_deb ( // [R23]
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .c_if        (c_if)
  );

  ris_mode_e   mode_ff, nxt_mode;
  logic        sel_ff, nxt_sel;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] st_cnt_ff, blink_cnt_ff;
  logic [2:0]  phase_ff;
  logic [31:0] wd_cnt_ff [2];
  logic [1:0]  tone, marker, wd_ok, ok;

  // per input pilot tone and loop marker detection
  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : g_in
      logic [31:0] pil_cnt_ff, mk_cnt_ff;
      wire  [5:0]  ch       = smp_chan_in[6*n +: 6];
      wire         pil_ch   = double_rate_in[n] ? (ch == `RIS_PILOT_CH_2FS)
                                                : (ch == `RIS_PILOT_CH_1FS); // [R13] [R21]
      wire         pil_hit  = smp_valid_in[n] && pil_ch &&
                              (smp_level_in[24*n +: 24] > `RIS_PILOT_THRESH); // [R13]
      wire         mk_ch    = double_rate_in[n] ? (ch[1:0] == 2'h3 && !ch[5])
                                                : (ch[2:0] == 3'h7); // [R20] [R21]
      wire         mk_hit   = smp_valid_in[n] && mk_ch && loop_marker_signal_in[n];
      // absence counters start saturated, so nothing is present after reset
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          pil_cnt_ff <= 32'hFFFFFFFF;
          mk_cnt_ff  <= 32'hFFFFFFFF;
        end else begin
          pil_cnt_ff <= pil_hit ? 32'h0 : pil_cnt_ff + {31'h0, pil_cnt_ff != 32'hFFFFFFFF};
          mk_cnt_ff  <= mk_hit  ? 32'h0 : mk_cnt_ff  + {31'h0, mk_cnt_ff  != 32'hFFFFFFFF};
        end
      end
      assign tone[n]   = pil_cnt_ff <= 32'(PILOT_LOSS_CYC); // [R14] [R12]
      assign marker[n] = mk_cnt_ff  <  32'(MARK_HOLD_CYC);
      // watchdog: each debounced change of remote input n restarts the window
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          wd_cnt_ff[n] <= 32'h0;
        end else if (c_if.change[n]) begin
          wd_cnt_ff[n] <= 32'h0; // [R16] [R17]
        end else if (wd_cnt_ff[n] != 32'hFFFFFFFF) begin
          wd_cnt_ff[n] <= wd_cnt_ff[n] + 32'h1;
        end
      end
      assign wd_ok[n] = wd_cnt_ff[n] < 32'(WD_CYC); // [R16]
    end
  endgenerate

  // mode classification
  wire is_lock  = mode_ff inside {RIS_LOCK1, RIS_LOCK2, RIS_LOCK_RED};
  wire is_mark  = mode_ff inside {RIS_MARK1, RIS_MARK2, RIS_MARK_RED};
  wire is_wd    = mode_ff inside {RIS_WD1, RIS_WD2};
  wire is_pilot = mode_ff inside {RIS_PILOT1, RIS_PILOT2, RIS_PILOT_RED};
  wire is_red   = mode_ff inside {RIS_LOCK_RED, RIS_MARK_RED, RIS_PILOT_RED};
  wire is_pri   = !is_red && mode_ff != RIS_MANUAL; // [R4]
  wire pri_idx  = mode_ff inside {RIS_LOCK2, RIS_MARK2, RIS_WD2, RIS_PILOT2};

  // condition of each input for the active mode
  // watchdog binds only the prioritised input; the fallback needs lock alone
  assign ok = lock_in & (is_mark ? marker : is_pilot ? tone
                       : is_wd ? (wd_ok | (pri_idx ? 2'h1 : 2'h2)) : 2'h3); // [R4] [R10]

  // user actions: remote 3/4 act like the two buttons
  wire sel_press  = c_if.press[2] | c_if.press[4]; // [R15]
  wire prio_press = c_if.press[3] | c_if.press[5]; // [R3] [R15]
  // remote 1/2 are level forces except while they serve as watchdog triggers
  wire force1     = !is_wd && c_if.level[0]; // [R15]
  wire force2     = !is_wd && c_if.level[1] && !c_if.level[0]; // [R15]
  wire man_ok     = mode_ff == RIS_MANUAL || (is_red && ok == 2'h3); // [R5] [R7] [R9] [R12]
  wire st_active  = st_cnt_ff < 32'(SELFTEST_CYC);

  // avalon decode; one wait state on every access
  wire req        = avs_read_in | avs_write_in;
  wire hit_ctrl   = avs_address_in == `RIS_REG_CTRL;
  wire hit_stat   = avs_address_in == `RIS_REG_STATUS;
  wire wr_mode    = avs_write_in && ack_ff && hit_ctrl &&
                    avs_writedata_in[`RIS_CTRL_MODE_LSB +: 4] <= 4'(RIS_PILOT_RED);
  assign avs_waitrequest_out = req && !ack_ff;
  assign avs_readdata_out    = rdata_ff;

  // next mode: software write wins over a simultaneous button step
  always_comb begin
    nxt_mode = mode_ff;
    if (wr_mode) begin
      nxt_mode = ris_mode_e'(avs_writedata_in[`RIS_CTRL_MODE_LSB +: 4]);
    end else if (prio_press) begin
      nxt_mode = (mode_ff == RIS_PILOT_RED) ? RIS_MANUAL
                                            : ris_mode_e'(4'(mode_ff) + 4'h1); // [R22] [R3]
    end
  end

  // next selection; forces first, then the mode's own policy
  always_comb begin
    nxt_sel = sel_ff;
    if (force1) begin
      nxt_sel = 1'b0; // [R15]
    end else if (force2) begin
      nxt_sel = 1'b1; // [R15]
    end else if (is_pri) begin
      if (ok[pri_idx]) begin
        nxt_sel = pri_idx; // [R6] [R8] [R10] [R11]
      end else if (ok[!pri_idx]) begin
        nxt_sel = !pri_idx; // [R6] [R8] [R10] [R11]
      end
    end else if (sel_press && man_ok) begin
      nxt_sel = !sel_ff; // [R5]
    end else if (is_red && !ok[sel_ff] && ok[!sel_ff]) begin
      nxt_sel = !sel_ff; // [R7] [R9] [R12]
    end
  end

  // mode, selection and self test timer
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mode_ff   <= RIS_MANUAL;
      sel_ff    <= 1'b0;
      st_cnt_ff <= 32'h0;
    end else begin
      mode_ff   <= nxt_mode;
      sel_ff    <= nxt_sel;
      st_cnt_ff <= st_active ? st_cnt_ff + 32'h1 : st_cnt_ff;
    end
  end

  // blink divider: one enable per BLINK_CYC drives an 8-phase pattern
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      blink_cnt_ff <= 32'h0;
      phase_ff     <= 3'h0;
    end else if (blink_cnt_ff >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_ff <= 32'h0;
      phase_ff     <= phase_ff + 3'h1;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h1;
    end
  end
  wire blink     = phase_ff[1];
  wire heartbeat = phase_ff == 3'h0 || phase_ff == 3'h2;

  // indicators; watchdog masks the port leds and the mode section with blink, the marker leds show the heartbeat
  generate
    for (n = 0; n < 2; n++) begin : g_led
      wire selected = sel_ff == 1'(n);
      wire port_on  = !selected ? 1'b0 : (lock_in[n] ? 1'b1 : blink); // [R2]
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          port_led_out[n]   <= 1'b0;
          marker_led_out[n] <= 1'b0;
        end else begin
          port_led_out[n]   <= st_active ? (c_if.level[n] & blink) // [R19]
                                         : (is_wd ? port_on & blink : port_on); // [R18]
          marker_led_out[n] <= is_wd ? heartbeat : marker[n] & selected; // [R1] [R18]
        end
      end
    end
  endgenerate

  // priority section and status register read
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mode_led_out    <= `RIS_MODE_RESET;
      mode_led_en_out <= 1'b0;
      sel_input_out   <= 1'b0;
      ack_ff          <= 1'b0;
      rdata_ff        <= 32'h0;
    end else begin
      mode_led_out    <= 4'(mode_ff);
      mode_led_en_out <= is_wd ? blink : 1'b1; // [R18]
      sel_input_out   <= sel_ff;
      ack_ff          <= req && !ack_ff;
      if (req && !ack_ff) begin
        rdata_ff <= hit_ctrl ? {28'h0, 4'(mode_ff)}
                  : hit_stat ? {20'h0, st_active, wd_ok, tone, marker, lock_in,
                                ok, sel_ff}
                  : 32'h0;
      end
    end
  end

  // checks
  sequence s_req_wait;
    req && !ack_ff;
  endsequence
  sequence s_req_done;
    ##1 (ack_ff && !avs_waitrequest_out);
  endsequence

  a_bus_one_wait: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_req_wait |-> s_req_done)
    else $error("bus answer not after one wait state");
  a_manual_sel_hold: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R5]
    (mode_ff == RIS_MANUAL && !sel_press && !force1 && !force2) |=> $stable(sel_ff))
    else $error("manual mode switched without a press");
  a_prio_return_in: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R6]
    (is_pri && ok[pri_idx] && !force1 && !force2) |=> sel_ff == $past(pri_idx))
    else $error("priority input not taken while it is valid");
  a_red_no_revert: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R7]
    (is_red && ok[sel_ff] && !sel_press && !force1 && !force2) |=> $stable(sel_ff))
    else $error("redundancy mode left a valid input");
  a_red_switch_away: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R9]
    (is_red && !ok[sel_ff] && ok[!sel_ff] && !force1 && !force2) |=> sel_ff != $past(sel_ff))
    else $error("redundancy mode kept a failed input");
  a_mode_wrap_step: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R22]
    (prio_press && !wr_mode && mode_ff == RIS_PILOT_RED) |=> mode_ff == RIS_MANUAL)
    else $error("mode did not wrap to manual");
  a_port_led_off: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R2]
    (!st_active && sel_ff == 1'b0 ##1 !st_active) |-> !port_led_out[1])
    else $error("port led lit for an unselected input");
  a_marker_led_sel: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R1]
    (!is_wd && marker[0] && sel_ff == 1'b0) |=> marker_led_out[0])
    else $error("marker led dark with marker on selected input");
  a_pilot_restore: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R14]
    g_in[0].pil_hit |=> tone[0] [*2])
    else $error("pilot tone not restored at once");
  a_wd_fallback: assert property (@(posedge core_clk_in) disable iff (reset_in) // [R10] [R16]
    (is_wd && !wd_ok[pri_idx] && lock_in[!pri_idx]) |=> sel_ff != $past(pri_idx))
    else $error("watchdog loss did not move to the other input");
endmodule : ris_switch_ctrl

// [bench/ris_contact_model.sv]
// contact and button model standing in for remote equipment and the front panel
`timescale 1ns/1ps
module ris_contact_model (
  // clock
  input  wire logic       core_clk_in,
  // contacts and buttons, high = closed or pressed
  output logic      [3:0] remote_out,
  output logic            sel_btn_out,
  output logic            pri_btn_out
);
  logic [5:0] cts_ff = 6'h01; // contact 1 closed so the power-up test has something to show
  logic       wd_run = 1'b0;
  int         wd_cnt = 0;

  // bits 3:0 remote contacts, bit 4 select button, bit 5 priority button
  assign remote_out  = cts_ff[3:0];
  assign sel_btn_out = cts_ff[4];
  assign pri_btn_out = cts_ff[5];

  // held far beyond the debounce time, so each press is one clean event
  task press(input int idx);
    cts_ff[idx] <= 1'b1;
    repeat (12) @(posedge core_clk_in);
    cts_ff[idx] <= 1'b0;
    repeat (12) @(posedge core_clk_in);
  endtask : press

  task set_level(input int idx, input logic v);
    cts_ff[idx] <= v;
    repeat (20) @(posedge core_clk_in);
  endtask : set_level

  // watchdog contact flips every 40 cycles, well inside the allowed period
  always @(posedge core_clk_in) begin
    wd_cnt <= (wd_run && wd_cnt < 39) ? wd_cnt + 1 : 0;
    if (wd_run && wd_cnt == 39) cts_ff[0] <= ~cts_ff[0];
  end
endmodule : ris_contact_model

// [bench/testbench.sv]
// self-checking bench of the input switch control
`timescale 1ns/1ps
module testbench;
  logic        core_clk_in, reset_in, avs_read_in, avs_write_in;
  logic [3:0]  avs_address_in;
  logic [31:0] avs_writedata_in;
  logic [31:0] avs_readdata_out, rdv;
  logic        avs_waitrequest_out, btn_sel, btn_pri, sel_input_out, mode_led_en_out;
  logic [3:0]  remote, mode_led_out;
  logic [1:0]  lock_in, double_rate_in, smp_valid_in;
  logic [11:0] smp_chan_in;
  logic [47:0] smp_level_in;
  logic [1:0]  loop_marker_signal_in, port_led_out, marker_led_out;
  logic [1:0]  pilot_on = 2'h0, marker_on = 2'h0;
  logic [2:0]  tick = 3'h0;
  int          errors = 0, checked = 0, cyc = 0;

  ris_switch_ctrl #(.PILOT_LOSS_CYC(50), .WD_CYC(200), .DEB_CYC(4), .SELFTEST_CYC(100),
    .MARK_HOLD_CYC(20), .BLINK_CYC(4)) u_ris_switch_ctrl (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .remote_control_input_in(remote),
    .btn_select_in(btn_sel), .btn_priority_in(btn_pri), .lock_in(lock_in),
    .double_rate_in(double_rate_in), .smp_valid_in(smp_valid_in), .smp_chan_in(smp_chan_in),
    .smp_level_in(smp_level_in), .loop_marker_signal_in(loop_marker_signal_in),
    .sel_input_out(sel_input_out), .port_led_out(port_led_out),
    .marker_led_out(marker_led_out), .mode_led_out(mode_led_out),
    .mode_led_en_out(mode_led_en_out));
  ris_contact_model u_ris_contact_model (.core_clk_in(core_clk_in), .remote_out(remote),
    .sel_btn_out(btn_sel), .pri_btn_out(btn_pri));

  always #20 core_clk_in = ~core_clk_in;

  // a hang ends the run as a failure instead of running forever
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errors++;
      report_and_stop();
    end
  end

  // strobe every 4 cycles, alternating the tone channel and a marker channel
  always @(posedge core_clk_in) begin
    tick <= tick + 3'h1;
    smp_valid_in <= {2{tick[1:0] == 2'h3}};
    smp_chan_in <= tick[2] ? {2{6'h07}} : (double_rate_in[0] ? {2{6'h1B}} : {2{6'h37}});
    smp_level_in <= {(pilot_on[1] & ~tick[2]) ? 24'h020000 : 24'h000100,
                     (pilot_on[0] & ~tick[2]) ? 24'h020000 : 24'h000100};
    loop_marker_signal_in <= marker_on & {2{tick[2]}};
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task cy(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cy

  // one bus cycle; request held until waitrequest is seen low at a rising edge
  task av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    @(posedge core_clk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge core_clk_in);
    end
    rdv = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : av_xfer

  task set_mode(input logic [3:0] m);
    av_xfer(1'b1, 4'h0, {28'h0, m});
    cy(3);
    check("mode", mode_led_out, m);
  endtask : set_mode

  // counts lit cycles of both port leds and the mode section
  task watch(input int n, output int a, output int b, output int e);
    a = 0;
    b = 0;
    e = 0;
    repeat (n) begin
      @(posedge core_clk_in);
      a += int'(port_led_out[0] === 1'b1);
      b += int'(port_led_out[1] === 1'b1);
      e += int'(mode_led_en_out === 1'b1);
    end
  endtask : watch

  task t_selftest;
    int a, b, e;
    cy(20);
    watch(48, a, b, e);
    check("test_led1", (a > 0 && a < 48), 1'b1);
    check("test_led2", b, 0);
    u_ris_contact_model.set_level(0, 1'b0);
    cy(80);
  endtask : t_selftest

  task t_regs;
    av_xfer(1'b0, 4'h0, 32'h0);
    check("ctrl_reset", rdv, 32'h0);
    av_xfer(1'b1, 4'h0, 32'hC);
    cy(3);
    check("mode_kept", mode_led_out, 4'h0);
    av_xfer(1'b1, 4'hC, 32'h5);
    av_xfer(1'b0, 4'h8, 32'h0);
    check("unmapped", rdv, 32'h0);
    check("sel_reset", sel_input_out, 1'b0);
  endtask : t_regs

  task t_priority;
    for (int i = 1; i <= 12; i++) begin
      u_ris_contact_model.press(i == 12 ? 3 : 5);
      check("prio_step", mode_led_out, i % 12);
    end
  endtask : t_priority

  task t_manual;
    int a, b, e;
    lock_in <= 2'h3;
    cy(10);
    u_ris_contact_model.press(4);
    check("man_press", sel_input_out, 1'b1);
    u_ris_contact_model.press(2);
    check("remote_sel", sel_input_out, 1'b0);
    lock_in <= 2'h2;
    cy(20);
    check("man_no_auto", sel_input_out, 1'b0);
    watch(48, a, b, e);
    check("blink_nolock", (a > 0 && a < 48 && b == 0), 1'b1);
    lock_in <= 2'h3;
    u_ris_contact_model.set_level(1, 1'b1);
    check("force2", sel_input_out, 1'b1);
    u_ris_contact_model.set_level(1, 1'b0);
  endtask : t_manual

  task t_lock;
    int a, b, e;
    for (int p = 0; p < 2; p++) begin
      set_mode(4'(p + 1));
      cy(10);
      check("lp_pref", sel_input_out, p[0]);
      u_ris_contact_model.press(4);
      check("lp_ignore", sel_input_out, p[0]);
      lock_in <= p[0] ? 2'h1 : 2'h2;
      cy(10);
      check("lp_fall", sel_input_out, p == 0);
      lock_in <= 2'h3;
      cy(10);
      check("lp_back", sel_input_out, p[0]);
    end
    watch(48, a, b, e);
    check("led_steady", (a == 0 && b == 48), 1'b1);
    set_mode(4'h3);
    lock_in <= 2'h1;
    cy(10);
    check("lr_switch", sel_input_out, 1'b0);
    lock_in <= 2'h3;
    cy(10);
    check("lr_stay", sel_input_out, 1'b0);
    u_ris_contact_model.press(4);
    check("lr_select", sel_input_out, 1'b1);
    lock_in <= 2'h2;
    u_ris_contact_model.press(4);
    check("lr_refuse", sel_input_out, 1'b1);
    lock_in <= 2'h3;
  endtask : t_lock

  task t_marker;
    set_mode(4'h4);
    marker_on <= 2'h3;
    cy(40);
    check("mk_pref", {marker_led_out, sel_input_out}, 3'h2);
    marker_on <= 2'h2;
    cy(40);
    check("mk_fall", {marker_led_out, sel_input_out}, 3'h5);
    marker_on <= 2'h3;
    cy(40);
    check("mk_back", sel_input_out, 1'b0);
    set_mode(4'h6);
    marker_on <= 2'h2;
    cy(40);
    check("mr_switch", sel_input_out, 1'b1);
    marker_on <= 2'h3;
    cy(40);
    check("mr_stay", sel_input_out, 1'b1);
    u_ris_contact_model.press(4);
    check("mr_select", sel_input_out, 1'b0);
    marker_on <= 2'h0;
    cy(40);
    check("mk_off", marker_led_out, 2'h0);
  endtask : t_marker

  task t_pilot;
    set_mode(4'h9);
    pilot_on <= 2'h3;
    cy(20);
    check("pt_pref", sel_input_out, 1'b0);
    pilot_on <= 2'h2;
    cy(30);
    check("pt_hold", sel_input_out, 1'b0);
    cy(60);
    check("pt_lost", sel_input_out, 1'b1);
    pilot_on <= 2'h3;
    cy(20);
    check("pt_back", sel_input_out, 1'b0);
    double_rate_in <= 2'h3;
    set_mode(4'hB);
    cy(20);
    av_xfer(1'b0, 4'h4, 32'h0);
    check("tone_2x", rdv[8:7], 2'h3);
    pilot_on <= 2'h2;
    cy(100);
    check("pr_switch", sel_input_out, 1'b1);
    pilot_on <= 2'h3;
    cy(20);
    check("pr_stay", sel_input_out, 1'b1);
    double_rate_in <= 2'h0;
  endtask : t_pilot

  task t_watchdog;
    int a, b, e;
    set_mode(4'h7);
    u_ris_contact_model.wd_run <= 1'b1;
    cy(100);
    check("wd_pref", sel_input_out, 1'b0);
    watch(48, a, b, e);
    check("wd_blink", (e > 0 && e < 48), 1'b1);
    u_ris_contact_model.wd_run <= 1'b0;
    cy(300);
    check("wd_lost", sel_input_out, 1'b1);
    u_ris_contact_model.wd_run <= 1'b1;
    cy(100);
    check("wd_back", sel_input_out, 1'b0);
  endtask : t_watchdog

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    core_clk_in = 1'b0;
    reset_in <= 1'b1;
    avs_address_in <= 4'h0;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    avs_writedata_in <= 32'h0;
    lock_in <= 2'h0;
    double_rate_in <= 2'h0;
    cy(20);
    reset_in <= 1'b0;
    t_selftest();
    t_regs();
    t_priority();
    t_manual();
    t_lock();
    t_marker();
    t_pilot();
    t_watchdog();
    report_and_stop();
  end
endmodule : testbench
